// ===== src/dcw_pkg.sv
// Constants and types of the device setup word decoder.
// Assumes a single 40 MHz clock domain and an APB master of 32-bit data.
package dcw_pkg;

    // ----------------------------------------------------------------
    // Setup word layout
    // ----------------------------------------------------------------
    localparam int WORD_W = 14;
    localparam logic [13:0] WORD_UNPROG = 14'h31ff; // All implemented ones
    localparam logic [13:0] WORD_IMPL_MASK = 14'h31ff; // Bits 11..9 absent
    localparam int BIT_TRIM_HI = 13;
    localparam int BIT_TRIM_LO = 12;
    localparam int BIT_DATA_PROT_N = 8;
    localparam int BIT_PROG_PROT_N = 7;
    localparam int BIT_BROWNOUT_ON = 6;
    localparam int BIT_RESET_PIN_SEL = 5;
    localparam int BIT_PWRUP_ON_N = 4;
    localparam int BIT_WATCHDOG_ON = 3;
    localparam int BIT_OSC_HI = 2;
    localparam int BIT_OSC_LO = 0;

    // ----------------------------------------------------------------
    // Address map (word index = paddr[16:2])
    // ----------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam logic [14:0] IDX_CFG_SPACE_LO = 15'h2000;
    localparam logic [14:0] IDX_CFG_SPACE_HI = 15'h3fff;
    localparam logic [14:0] IDX_SETUP_WORD = 15'h2007;
    localparam logic [14:0] IDX_DECODE_STATUS = 15'h4000;

    // Status register field positions
    localparam int ST_PROG_MODE = 16;
    localparam int ST_LOADING = 17;

    // ----------------------------------------------------------------
    // Oscillator select codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DCW_LOW_POWER_CRYSTAL_MODE = 3'h0,
        DCW_CRYSTAL_MODE = 3'h1,
        DCW_FAST_CRYSTAL_MODE = 3'h2,
        DCW_EXTERNAL_CLOCK_MODE = 3'h3,
        DCW_INTERNAL_OSC_MODE_IO = 3'h4,
        DCW_INTERNAL_OSC_MODE_CLOCK_OUT_PIN = 3'h5,
        DCW_RESISTOR_CAPACITOR_MODE_IO = 3'h6,
        DCW_RESISTOR_CAPACITOR_MODE_CLOCK_OUT_PIN = 3'h7
    } dcw_osc_select_e;

    // Loader sequence, Gray along load -> run -> prog
    typedef enum logic [1:0] {
        DCW_ST_LOAD = 2'h0,
        DCW_ST_RUN = 2'h1,
        DCW_ST_PROG = 2'h3
    } dcw_state_e;

    // Decoded static settings
    typedef struct packed {
        logic [1:0] bandgap_trim;
        logic data_protect_n;
        logic program_protect_n;
        logic brownout_detect_on;
        logic reset_pin_select;
        logic powerup_delay_on_n;
        logic watchdog_on;
        dcw_osc_select_e osc_select;
    } dcw_settings_s;

    // Oscillator pin plan
    typedef struct packed {
        logic crystal_drive;       // Both oscillator pins on crystal
        logic rc_on_pin5;          // RC network on port pin 5
        logic internal_osc;        // Internal oscillator runs core
        logic ext_clock_in_ok;     // Osc input pin may take a clock
        logic clock_out_pin;       // Port pin 4 drives clock out
        logic pin4_is_io;
        logic pin5_is_io;
    } dcw_osc_plan_s;

endpackage

// ===== src/dcw_config_decode.sv
// Device setup word store, loader and decoder with APB access.
// Assumes prog_mode_pin and external_reset_pin come from pins (async),
// and that the APB master follows the standard setup/access sequence.
//
// Functional notes
// RULE1: Setup word sits at program index 2007h.
// RULE2: Config space reachable only in programming mode.
// RULE3: Programmed bit reads zero, unprogrammed reads one.
// RULE4: Bits 11 to 9 always read zero.
// RULE5: Bits 13:12 drive bandgap trim, 00 lowest.
// RULE6: Programmer saves and restores trim around erase.
// RULE7: Bit 8 low protects data EEPROM.
// RULE8: Bit 7 low protects program memory.
// RULE9: Lifting data protection erases data EEPROM.
// RULE10: Lifting program protection erases program memory.
// RULE11: Protected EEPROM: CPU keeps access, programmer denied.
// RULE12: Bit 6 high enables brown-out detector.
// RULE13: Brown-out enable leaves power-up delay alone.
// RULE14: Bit 5 selects reset pin or I/O.
// RULE15: Bit 4 low enables power-up delay timer.
// RULE16: Bit 3 high enables watchdog timer.
// RULE17: Codes 111/110 select RC on pin 5.
// RULE18: Codes 101/100 select internal oscillator.
// RULE19: Code 011 takes external clock on pin 5.
// RULE20: Codes 010/001/000 fast, standard, low-power crystal.
// RULE21: Reset pin stops internal or RC oscillator.
// RULE22: Crystal modes also accept external clock input.
// RULE23: Word latched at reset, held static afterwards. The code also relatches it each time programming mode is left.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/100ps

module dcw_config_decode
    import dcw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic prog_mode_pin,
    input wire logic external_reset_pin_n,
    output dcw_settings_s settings,
    output dcw_osc_plan_s osc_plan,
    output logic powerup_delay_timer_on,
    output logic internal_reset_n,
    output logic reset_pin_is_io,
    output logic internal_osc_stop,
    output logic cpu_ee_access_ok,
    output logic prog_ee_access_ok,
    output logic prog_pm_access_ok,
    output logic data_erase_start,
    output logic program_erase_start
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic prog_meta_reg;
    logic prog_sync_reg;
    logic rst_meta_reg;
    logic rst_sync_reg;

    // Two flops per pin before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_meta_reg <= 1'b0;
            prog_sync_reg <= 1'b0;
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= 1'b1;
        end else begin
            prog_meta_reg <= prog_mode_pin;
            prog_sync_reg <= prog_meta_reg;
            rst_meta_reg <= external_reset_pin_n;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Loader state
    // ----------------------------------------------------------------
    dcw_state_e state_reg;
    dcw_state_e state_next;

    // Next state: load, then follow the programming pin; leaving programming reloads
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DCW_ST_LOAD: begin
                state_next = prog_sync_reg ? DCW_ST_PROG : DCW_ST_RUN;
            end
            DCW_ST_RUN: begin
                if (prog_sync_reg) begin
                    state_next = DCW_ST_PROG;
                end
            end
            DCW_ST_PROG: begin
                if (!prog_sync_reg) begin
                    state_next = DCW_ST_LOAD; // see RULE23
                end
            end
            default: begin
                state_next = DCW_ST_LOAD;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= DCW_ST_LOAD;
        end else begin
            state_reg <= state_next;
        end
    end

    logic in_prog;
    assign in_prog = (state_reg == DCW_ST_PROG);

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic [14:0] idx;
    logic hit_cfg_space;
    logic hit_word;
    logic hit_status;
    logic bad_access;
    logic setup_phase;
    logic wr_take;

    assign idx = paddr[16:2];
    assign hit_cfg_space = (idx >= IDX_CFG_SPACE_LO) &&
                           (idx <= IDX_CFG_SPACE_HI);
    assign hit_word = (idx == IDX_SETUP_WORD); // see RULE1
    assign hit_status = (idx == IDX_DECODE_STATUS);
    // Config space refused outside programming; unmapped refused
    assign bad_access = (paddr[1:0] != 2'h0) ||
                        (hit_cfg_space && !in_prog) || // see RULE2
                        (!hit_cfg_space && !hit_status) ||
                        (hit_status && pwrite);
    assign setup_phase = psel && !penable;
    assign wr_take = psel && penable && pready && pwrite && !pslverr;

    // ----------------------------------------------------------------
    // Non-volatile setup word
    // ----------------------------------------------------------------
    logic [13:0] word_reg;
    logic [13:0] word_next;

    // Unimplemented bits forced low on every write
    assign word_next = pwdata[13:0] & WORD_IMPL_MASK; // see RULE4

    // Word store, unprogrammed ones at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_reg <= WORD_UNPROG; // see RULE3
        end else if (wr_take && hit_word) begin
            word_reg <= word_next;
        end
    end

    // Erase when a protection bit goes from programmed to erased
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_erase_start <= 1'b0;
            program_erase_start <= 1'b0;
        end else begin
            data_erase_start <= wr_take && hit_word &&
                !word_reg[BIT_DATA_PROT_N] &&
                word_next[BIT_DATA_PROT_N]; // see RULE9
            program_erase_start <= wr_take && hit_word &&
                !word_reg[BIT_PROG_PROT_N] &&
                word_next[BIT_PROG_PROT_N]; // see RULE10
        end
    end

    // ----------------------------------------------------------------
    // Holding latches for the decoded settings
    // ----------------------------------------------------------------
    logic [13:0] shadow_reg;

    // Captured only in the load state, static otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_reg <= WORD_UNPROG;
        end else if (state_reg == DCW_ST_LOAD) begin
            shadow_reg <= word_reg; // see RULE23
        end
    end

    // Field split of the held word
    always_comb begin
        settings.bandgap_trim =
            shadow_reg[BIT_TRIM_HI:BIT_TRIM_LO]; // see RULE5
        settings.data_protect_n = shadow_reg[BIT_DATA_PROT_N]; // see RULE7
        settings.program_protect_n =
            shadow_reg[BIT_PROG_PROT_N]; // see RULE8
        settings.brownout_detect_on =
            shadow_reg[BIT_BROWNOUT_ON]; // see RULE12
        settings.reset_pin_select = shadow_reg[BIT_RESET_PIN_SEL];
        settings.powerup_delay_on_n = shadow_reg[BIT_PWRUP_ON_N];
        settings.watchdog_on = shadow_reg[BIT_WATCHDOG_ON]; // see RULE16
        settings.osc_select =
            dcw_osc_select_e'(shadow_reg[BIT_OSC_HI:BIT_OSC_LO]);
    end

    // Power-up delay from its own bit only, never from brown-out
    assign powerup_delay_timer_on =
        !shadow_reg[BIT_PWRUP_ON_N]; // see RULE15 see RULE13

    // ----------------------------------------------------------------
    // Reset pin function
    // ----------------------------------------------------------------
    // I/O mode ties the internal reset inactive
    assign reset_pin_is_io = !settings.reset_pin_select; // see RULE14
    assign internal_reset_n = settings.reset_pin_select ?
                              rst_sync_reg : 1'b1; // see RULE14

    // ----------------------------------------------------------------
    // Oscillator pin plan
    // ----------------------------------------------------------------
    always_comb begin
        osc_plan = '0;
        unique case (settings.osc_select)
            DCW_RESISTOR_CAPACITOR_MODE_CLOCK_OUT_PIN: begin
                osc_plan.rc_on_pin5 = 1'b1; // see RULE17
                osc_plan.clock_out_pin = 1'b1;
            end
            DCW_RESISTOR_CAPACITOR_MODE_IO: begin
                osc_plan.rc_on_pin5 = 1'b1; // see RULE17
                osc_plan.pin4_is_io = 1'b1;
            end
            DCW_INTERNAL_OSC_MODE_CLOCK_OUT_PIN: begin
                osc_plan.internal_osc = 1'b1; // see RULE18
                osc_plan.clock_out_pin = 1'b1;
                osc_plan.pin5_is_io = 1'b1;
            end
            DCW_INTERNAL_OSC_MODE_IO: begin
                osc_plan.internal_osc = 1'b1; // see RULE18
                osc_plan.pin4_is_io = 1'b1;
                osc_plan.pin5_is_io = 1'b1;
            end
            DCW_EXTERNAL_CLOCK_MODE: begin
                osc_plan.ext_clock_in_ok = 1'b1; // see RULE19
                osc_plan.pin4_is_io = 1'b1;
            end
            DCW_FAST_CRYSTAL_MODE,
            DCW_CRYSTAL_MODE,
            DCW_LOW_POWER_CRYSTAL_MODE: begin
                osc_plan.crystal_drive = 1'b1; // see RULE20
                osc_plan.ext_clock_in_ok = 1'b1; // see RULE22
            end
        endcase
    end

    // Held reset stops the on-chip RC or internal oscillator
    assign internal_osc_stop = (osc_plan.internal_osc ||
                                osc_plan.rc_on_pin5) &&
                               settings.reset_pin_select &&
                               !rst_sync_reg; // see RULE21

    // ----------------------------------------------------------------
    // Memory access gates
    // ----------------------------------------------------------------
    // CPU access never depends on data protection
    assign cpu_ee_access_ok = 1'b1; // see RULE11
    assign prog_ee_access_ok = in_prog &&
                               settings.data_protect_n; // see RULE11
    assign prog_pm_access_ok = in_prog &&
                               settings.program_protect_n; // see RULE8

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------
    logic [31:0] rdata_next;

    // Read mux, zero outside the setup word within config space
    always_comb begin
        rdata_next = 32'h0;
        if (hit_word) begin
            rdata_next[13:0] = word_reg & WORD_IMPL_MASK; // see RULE4
        end else if (hit_status) begin
            rdata_next[13:0] = shadow_reg;
            rdata_next[ST_PROG_MODE] = in_prog;
            rdata_next[ST_LOADING] = (state_reg == DCW_ST_LOAD);
        end
    end

    // One answer per transfer, in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (setup_phase) begin
            pready <= 1'b1;
            pslverr <= bad_access;
            prdata <= (bad_access || pwrite) ? 32'h0 : rdata_next;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // dcw_config_decode

// ===== tb/dcw_chk_props.sv
// Checker for the setup word decoder, watching its top-level ports.
// Assumes the single pclk domain with presetn as its async reset.
`timescale 1ns/100ps

module dcw_chk
    import dcw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire dcw_settings_s settings,
    input wire logic powerup_delay_timer_on,
    input wire logic internal_reset_n,
    input wire logic reset_pin_is_io,
    input wire logic internal_osc_stop,
    input wire logic cpu_ee_access_ok,
    input wire logic prog_ee_access_ok,
    input wire logic prog_pm_access_ok,
    input wire logic data_erase_start,
    input wire logic program_erase_start
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answers and read-back format
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    unimpl_zero_a: assert property (
        pready && !pslverr |-> prdata[11:9] == 3'h0)
        else $error("unused word bits read nonzero");

    // Static decode relations
    pwrup_timer_a: assert property (
        powerup_delay_timer_on == !settings.powerup_delay_on_n)
        else $error("power-up timer enable wrong");
    reset_io_a: assert property (
        reset_pin_is_io != settings.reset_pin_select)
        else $error("reset pin function wrong");
    int_reset_a: assert property (
        !settings.reset_pin_select |-> internal_reset_n)
        else $error("internal reset active with pin as io");
    osc_stop_a: assert property (internal_osc_stop |->
        settings.osc_select[2] && settings.reset_pin_select)
        else $error("oscillator stop in wrong mode");
    cpu_ee_a: assert property (cpu_ee_access_ok)
        else $error("cpu lost eeprom access");
    prog_ee_a: assert property (
        prog_ee_access_ok |-> settings.data_protect_n)
        else $error("programmer reaches protected eeprom");
    prog_pm_a: assert property (
        prog_pm_access_ok |-> settings.program_protect_n)
        else $error("programmer reaches protected program memory");
    settings_hold_a: assert property (
        prog_pm_access_ok && $past(prog_pm_access_ok) |-> $stable(settings))
        else $error("settings moved during programming");

    // Erase pulses follow a write that sets the protect bit
    data_erase_a: assert property (data_erase_start |->
        $past(psel && penable && pready && pwrite && pwdata[8]))
        else $error("data erase without unprotect write");
    prog_erase_a: assert property (program_erase_start |->
        $past(psel && penable && pready && pwrite && pwdata[7]))
        else $error("program erase without unprotect write");

    // Main scenarios reached
    cov_erase: cover property (data_erase_start && program_erase_start);
    cov_refuse: cover property (pready && pslverr);
    cov_stop: cover property (internal_osc_stop);
endmodule // dcw_chk

bind dcw_config_decode dcw_chk u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .settings(settings),
    .powerup_delay_timer_on(powerup_delay_timer_on),
    .internal_reset_n(internal_reset_n),
    .reset_pin_is_io(reset_pin_is_io),
    .internal_osc_stop(internal_osc_stop),
    .cpu_ee_access_ok(cpu_ee_access_ok),
    .prog_ee_access_ok(prog_ee_access_ok),
    .prog_pm_access_ok(prog_pm_access_ok),
    .data_erase_start(data_erase_start),
    .program_erase_start(program_erase_start)
);

// ===== tb/dcw_prog_model.sv
// Device programmer model: APB master plus programming-mode pin.
// Assumes the setup word decoder answers on the far side.
`timescale 1ns/100ps

module dcw_prog_model
    import dcw_pkg::*;
(
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    output logic prog_mode_pin
);
    logic [31:0] rd;
    logic err;

    // Idle bus, run mode; address and data open until first transfer
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        prog_mode_pin = 1'b0;
    end

    // One transfer; holds the request until pready
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench watchdog ends a wait that never answers
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a; // Released lines lose old value
        pwdata <= ~d;
    endtask

    // Enter or leave programming mode, wait out sync and reload
    task automatic mode(input logic on);
        @(posedge pclk);
        prog_mode_pin <= on;
        repeat (6) @(posedge pclk);
    endtask

    // Rewrite the word, keeping the factory trim bits
    task automatic keep(input logic [13:0] w);
        xfer(1'b0, 17'h0801c, 32'h0);
        xfer(1'b1, 17'h0801c, {18'h0, rd[13:12], w[11:0]});
    endtask
endmodule // dcw_prog_model

// ===== tb/testbench.sv
// Self-checking bench for the setup word decoder.
// Assumes the programmer model and the bound checker.
`timescale 1ns/100ps

`define CHK(n, e, a) begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
        mismatches++; \
        $display("CHECK FAILED %s exp %h seen %h", n, (e), (a)); \
    end \
end

module testbench
    import dcw_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ext_rst_n = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, prog_mode_pin;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    dcw_settings_s settings;
    dcw_osc_plan_s osc_plan;
    logic pd_on, rst_n_int, rst_io, osc_stop, cpu_ok, pee_ok, ppm_ok;
    logic de_start, pe_start;
    logic [13:0] w;
    logic [6:0] op;
    logic [2:0] k;
    int mismatches = 0;
    int cmp_count = 0;

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    dcw_config_decode dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_mode_pin(prog_mode_pin), .external_reset_pin_n(ext_rst_n),
        .settings(settings), .osc_plan(osc_plan),
        .powerup_delay_timer_on(pd_on), .internal_reset_n(rst_n_int),
        .reset_pin_is_io(rst_io), .internal_osc_stop(osc_stop),
        .cpu_ee_access_ok(cpu_ok), .prog_ee_access_ok(pee_ok),
        .prog_pm_access_ok(ppm_ok), .data_erase_start(de_start),
        .program_erase_start(pe_start));

    dcw_prog_model prog (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prog_mode_pin(prog_mode_pin));

    // Verdict and end of run
    task automatic test_done;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #100us;
        mismatches++;
        test_done;
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        `CHK("word", 11'h7ff, settings)
        prog.xfer(1'b0, 17'h0801c, 32'h0);
        `CHK("deny", 33'h100000000, {prog.err, prog.rd})
        prog.xfer(1'b0, 17'h00004, 32'h0);
        `CHK("user", 1'b1, prog.err)
        prog.xfer(1'b0, 17'h10000, 32'h0);
        `CHK("stat", 33'h0000031ff, {prog.err, prog.rd})
        prog.mode(1'b1);
        prog.xfer(1'b0, 17'h0801c, 32'h0);
        `CHK("read", 33'h0000031ff, {prog.err, prog.rd})
        prog.xfer(1'b0, 17'h08018, 32'h0);
        `CHK("other", 33'h000000000, {prog.err, prog.rd})
        prog.xfer(1'b0, 17'h0801e, 32'h0);
        `CHK("align", 1'b1, prog.err)
        for (int c = 0; c < 8; c++) begin
            k = 3'(c);
            w = {k[1:0], 3'h7, 2'h3, k[0], k[1], k[2], ~k[0], k};
            prog.xfer(1'b1, 17'h0801c, {18'h0, w});
            prog.xfer(1'b0, 17'h0801c, 32'h0);
            `CHK("back", {18'h0, w & 14'h31ff}, prog.rd)
            prog.mode(1'b0);
            `CHK("set", {w[13:12], w[8:0]}, settings)
            `CHK("powerup_delay_timer", ~k[2], pd_on)
            op = {k <= 3'h2,
                k >= 3'h6,
                k[2:1] == 2'h2,
                k <= 3'h3,
                k == 3'h7 || k == 3'h5,
                k == 3'h6 || k == 3'h4 || k == 3'h3,
                k[2:1] == 2'h2};
            `CHK("osc", op, osc_plan)
            ext_rst_n <= 1'b0;
            repeat (4) @(posedge pclk);
            `CHK("stop", k[2] & k[1], osc_stop)
            `CHK("rst", ~k[1], rst_n_int)
            `CHK("io", ~k[1], rst_io)
            ext_rst_n <= 1'b1;
            prog.mode(1'b1);
        end
        prog.keep(14'h007f);
        prog.mode(1'b0);
        `CHK("trim", 2'h3, settings.bandgap_trim)
        `CHK("dprot", 1'b0, settings.data_protect_n)
        prog.mode(1'b1);
        `CHK("pee", 1'b0, pee_ok)
        `CHK("ppm", 1'b0, ppm_ok)
        `CHK("cpu", 1'b1, cpu_ok)
        prog.keep(14'h01ff);
        #1;
        `CHK("erase", 2'h3, {de_start, pe_start})
        prog.keep(14'h01ff);
        #1;
        `CHK("noerase", 2'h0, {de_start, pe_start})
        test_done;
    end
endmodule // testbench
